// *** abs_out_defs.svh ***
`ifndef ABS_OUT_DEFS_SVH
`define ABS_OUT_DEFS_SVH

`define CLK_HZ          20000000
`define REQ_WAIT_MS     100
`define SETTLE_MS       400
`define REQ_WAIT_CYC    (`CLK_HZ / 1000 * `REQ_WAIT_MS)
`define SETTLE_CYC      (`CLK_HZ / 1000 * `SETTLE_MS)
`define BAUD_BPS        9600
`define BIT_CYC         (`CLK_HZ / `BAUD_BPS)
`define RATE_NUM        680
`define RATE_DEN        16383
`define RATE_UNIT_HZ    1000
`define RATE_THRESH     ((64'd20000000 * `RATE_DEN) / (4 * `RATE_NUM * `RATE_UNIT_HZ))

`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_MASK        8'h08
`define OFF_TURNS       8'h0C
`define OFF_COUNT       8'h10
`define OFF_STATE       8'h14

`define CTRL_SET_LSB    0
`define CTRL_DIR_BIT    14
`define CTRL_EDGE_LSB   15
`define CTRL_SERVO_BIT  17
`define CTRL_ERST_BIT   18
`define SET_RST         14'h0800
`define SET_MIN         14'h0010
`define EDGE_RST        2'h0
`define MASK_RST        3'h0

`define EV_REC_DONE     0
`define EV_ALM_DONE     1
`define EV_WRAP         2

`define TURN_MAX        17'h0_8000
`define TURN_MIN        17'h1_8000
`define CH_P            7'h50
`define CH_PLUS         7'h2B
`define CH_MINUS        7'h2D
`define CH_A            7'h41
`define CH_L            7'h4C
`define CH_M            7'h4D
`define CH_CR           7'h0D
`define CH_ZERO         7'h30
`define CH_HEX_A        7'h37

`endif

// *** abs_out_pkg.sv ***
`include "abs_out_defs.svh"
package abs_out_pkg;

    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_WAIT, SEQ_SERIAL, SEQ_SETTLE, SEQ_ALARM
    } seq_state_t;

    typedef enum logic [1:0] {
        EDGE_A_RISE, EDGE_A_FALL, EDGE_B_RISE, EDGE_B_FALL
    } edge_sel_t;

    typedef struct packed {
        logic        busy;
        logic        done;
        logic        tx;
        logic [3:0]  bit_idx;
        logic [11:0] bit_cnt;
        logic [9:0]  shreg;
    } tx_t;

    typedef struct packed {
        logic [1:0]  req_sync;
        logic        req_prev;
        seq_state_t  state;
        logic [22:0] timer;
        logic [2:0]  chr_idx;
        logic        chr_go;
        logic [16:0] turns;
        logic [15:0] st_pos;
        logic [15:0] mag;
        logic        neg;
        logic [15:0] alarm;
        logic [15:0] init_left;
        logic [17:0] rate_acc;
        logic [1:0]  quad;
        logic [31:0] rev_cnt;
        logic [13:0] pulse_set;
        logic        dir_sel;
        edge_sel_t   edge_sel;
        logic        servo_on;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        pa;
        logic        pb;
        logic        pc;
    } core_t;

endpackage : abs_out_pkg

// *** char_tx.sv ***
`timescale 1ns/1ns
`include "abs_out_defs.svh"
module char_tx #(
    parameter int BIT_CYCLES = `BIT_CYC
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       start,
    input  wire logic [6:0] data,
    output logic            tx,
    output logic            busy,
    output logic            done
);
    abs_out_pkg::tx_t s_q, s_d;

    if (BIT_CYCLES < 2 || BIT_CYCLES > 4095) begin : g_chk
        $error("char_tx: BIT_CYCLES out of range");
    end

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (!s_q.busy) begin
            if (start) begin
                // Stop, even parity, 7 data LSB first, start
                s_d.shreg   = {1'b1, ^data, data, 1'b0};
                s_d.busy    = 1'b1;
                s_d.bit_idx = 4'h0;
                s_d.bit_cnt = 12'h000;
                s_d.tx      = 1'b0;
            end
        end else if (s_q.bit_cnt == 12'(BIT_CYCLES - 1)) begin
            s_d.bit_cnt = 12'h000;
            if (s_q.bit_idx == 4'h9) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.tx   = 1'b1;
            end else begin
                s_d.bit_idx = s_q.bit_idx + 4'h1;
                s_d.tx      = s_q.shreg[s_q.bit_idx + 4'h1];
            end
        end else begin
            s_d.bit_cnt = s_q.bit_cnt + 12'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{busy: 1'b0, done: 1'b0, tx: 1'b1, bit_idx: 4'h0,
                     bit_cnt: 12'h000, shreg: 10'h3FF};
        end else begin
            s_q <= s_d;
        end
    end

    assign tx   = s_q.tx;
    assign busy = s_q.busy;
    assign done = s_q.done;
endmodule : char_tx

// *** abs_data_out.sv ***
`timescale 1ns/1ns
`include "abs_out_defs.svh"
module abs_data_out #(
    parameter int REQ_WAIT_CYCLES = `REQ_WAIT_CYC,
    parameter int SETTLE_CYCLES   = `SETTLE_CYC,
    parameter int BIT_CYCLES      = `BIT_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        absolute_data_request,
    input  wire logic        motion_step,
    input  wire logic        motion_fwd,
    input  wire logic [15:0] alarm_code,
    output logic             divided_phase_a_out,
    output logic             divided_phase_b_out,
    output logic             origin_pulse_out,
    output logic             irq
);
    localparam logic [17:0] RATE_THR = 18'(`RATE_THRESH);

    abs_out_pkg::core_t r_q, r_d;
    logic tx_line;
    logic tx_busy;
    logic tx_done;
    logic [6:0] chr;

    if (REQ_WAIT_CYCLES < 1 || REQ_WAIT_CYCLES > 8388607 ||
        SETTLE_CYCLES < 1 || SETTLE_CYCLES > 8388607) begin : g_chk
        $error("abs_data_out: wait counts out of range");
    end

    function automatic logic [6:0] hex_ch(input logic [3:0] d);
        return (d < 4'hA) ? `CH_ZERO + 7'(d) : `CH_HEX_A + 7'(d);
    endfunction : hex_ch

    function automatic logic [6:0] dec_ch(input logic [15:0] v,
                                          input logic [2:0]  pos);
        logic [15:0] q;
        q = v;
        for (int i = 0; i < 4; i++) begin
            if (3'(i) < 3'd4 - pos + 3'd2) begin
                q = q / 16'd10;
            end
        end
        return `CH_ZERO + 7'(q % 16'd10);
    endfunction : dec_ch

    // Character of the current record
    always_comb begin
        chr = `CH_CR;
        if (r_q.state == abs_out_pkg::SEQ_ALARM) begin
            unique case (r_q.chr_idx)
                3'd0: chr = `CH_A;
                3'd1: chr = `CH_L;
                3'd2: chr = `CH_M;
                3'd3: chr = hex_ch(r_q.alarm[15:12]);
                3'd4: chr = hex_ch(r_q.alarm[11:8]);
                3'd5: chr = hex_ch(r_q.alarm[7:4]);
                3'd6: chr = hex_ch(r_q.alarm[3:0]);
                3'd7: chr = `CH_CR;
            endcase
        end else begin
            unique case (r_q.chr_idx)
                3'd0: chr = `CH_P;
                3'd1: chr = r_q.neg ? `CH_MINUS : `CH_PLUS;
                3'd7: chr = `CH_CR;
                default: chr = dec_ch(r_q.mag, r_q.chr_idx);
            endcase
        end
    end

    char_tx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_tx (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (r_q.chr_go),
        .data    (chr),
        .tx      (tx_line),
        .busy    (tx_busy),
        .done    (tx_done)
    );

    always_comb begin
        logic        req_s;
        logic        acc_ok;
        logic        wr;
        logic        step_up;
        logic        out_step;
        logic        out_fwd;
        logic [15:0] st_top;
        logic [1:0]  nq;
        logic        ed;
        logic [2:0]  ev;
        req_s    = r_q.req_sync[1];
        acc_ok   = psel && penable && r_q.pready;
        wr       = acc_ok && pwrite;
        step_up  = 1'b0;
        out_step = 1'b0;
        out_fwd  = 1'b1;
        st_top   = {r_q.pulse_set, 2'b00} - 16'h0001;
        nq       = r_q.quad;
        ed       = 1'b0;
        ev       = 3'b000;

        r_d          = r_q;
        r_d.req_sync = {r_q.req_sync[0], absolute_data_request};
        r_d.req_prev = req_s;
        r_d.chr_go   = 1'b0;

        // Shaft tracking from internal motion steps
        if (motion_step) begin
            step_up = motion_fwd ^ r_q.dir_sel;
            if (step_up) begin
                if (r_q.st_pos >= st_top) begin
                    r_d.st_pos = 16'h0000;
                    ev[`EV_WRAP] = (r_q.turns == `TURN_MAX);
                    r_d.turns = ev[`EV_WRAP] ? `TURN_MIN
                              : r_q.turns + 17'h0_0001;
                end else begin
                    r_d.st_pos = r_q.st_pos + 16'h0001;
                end
            end else begin
                if (r_q.st_pos == 16'h0000) begin
                    r_d.st_pos = st_top;
                    ev[`EV_WRAP] = (r_q.turns == `TURN_MIN);
                    r_d.turns = ev[`EV_WRAP] ? `TURN_MAX
                              : r_q.turns - 17'h0_0001;
                end else begin
                    r_d.st_pos = r_q.st_pos - 16'h0001;
                end
            end
        end

        // Sequencer
        unique case (r_q.state)
            abs_out_pkg::SEQ_IDLE: begin
                if (motion_step) begin
                    out_step = 1'b1;
                    out_fwd  = motion_fwd;
                end
                if (!r_q.servo_on && req_s && !r_q.req_prev) begin
                    r_d.state = abs_out_pkg::SEQ_WAIT;
                    r_d.timer = 23'h00_0000;
                end else if (!r_q.servo_on && !req_s
                             && r_q.req_prev) begin
                    r_d.state   = abs_out_pkg::SEQ_ALARM;
                    r_d.alarm   = alarm_code;
                    r_d.chr_idx = 3'd0;
                    r_d.chr_go  = 1'b1;
                end
            end
            abs_out_pkg::SEQ_WAIT: begin
                if (!req_s) begin
                    r_d.state = abs_out_pkg::SEQ_IDLE;
                end else if (r_q.timer == 23'(REQ_WAIT_CYCLES - 1)) begin
                    r_d.state   = abs_out_pkg::SEQ_SERIAL;
                    r_d.rev_cnt = 32'h0000_0000;
                    r_d.neg     = r_q.turns[16];
                    r_d.mag     = r_q.turns[16] ? 16'(-r_q.turns)
                                                : r_q.turns[15:0];
                    r_d.chr_idx = 3'd0;
                    r_d.chr_go  = 1'b1;
                end else begin
                    r_d.timer = r_q.timer + 23'h00_0001;
                end
            end
            abs_out_pkg::SEQ_SERIAL, abs_out_pkg::SEQ_ALARM: begin
                if (tx_done) begin
                    if (r_q.chr_idx == 3'd7) begin
                        if (r_q.state == abs_out_pkg::SEQ_ALARM) begin
                            r_d.state = abs_out_pkg::SEQ_IDLE;
                            ev[`EV_ALM_DONE] = 1'b1;
                        end else begin
                            r_d.state     = abs_out_pkg::SEQ_SETTLE;
                            r_d.timer     = 23'h00_0000;
                            r_d.init_left = r_q.st_pos;
                            r_d.rate_acc  = 18'h0_0000;
                            ev[`EV_REC_DONE] = 1'b1;
                        end
                    end else begin
                        r_d.chr_idx = r_q.chr_idx + 3'd1;
                        r_d.chr_go  = 1'b1;
                    end
                end
            end
            abs_out_pkg::SEQ_SETTLE: begin
                // Accumulator paces edges at 4 x 680 kHz x setting / 16383
                if (r_q.init_left != 16'h0000) begin
                    if (r_q.rate_acc + 18'(r_q.pulse_set) >= RATE_THR) begin
                        r_d.rate_acc  = r_q.rate_acc + 18'(r_q.pulse_set)
                                      - RATE_THR;
                        r_d.init_left = r_q.init_left - 16'h0001;
                        out_step      = 1'b1;
                    end else begin
                        r_d.rate_acc = r_q.rate_acc + 18'(r_q.pulse_set);
                    end
                end
                if (r_q.timer == 23'(SETTLE_CYCLES - 1)) begin
                    r_d.state = abs_out_pkg::SEQ_IDLE;
                end else begin
                    r_d.timer = r_q.timer + 23'h00_0001;
                end
            end
            default: r_d.state = abs_out_pkg::SEQ_IDLE;
        endcase

        // Quadrature: forward advance makes B lead A
        if (out_step) begin
            nq          = out_fwd ? r_q.quad + 2'd1 : r_q.quad - 2'd1;
            r_d.quad    = nq;
            r_d.rev_cnt = out_fwd ? r_q.rev_cnt + 32'h0000_0001
                                  : r_q.rev_cnt - 32'h0000_0001;
            unique case (r_q.edge_sel)
                abs_out_pkg::EDGE_A_RISE: ed = !r_q.quad[1] && nq[1];
                abs_out_pkg::EDGE_A_FALL: ed = r_q.quad[1] && !nq[1];
                abs_out_pkg::EDGE_B_RISE:
                    ed = !(r_q.quad[1] ^ r_q.quad[0]) && (nq[1] ^ nq[0]);
                abs_out_pkg::EDGE_B_FALL:
                    ed = (r_q.quad[1] ^ r_q.quad[0]) && !(nq[1] ^ nq[0]);
            endcase
            // Origin pulse spans one phase A period
            if (ed) begin
                r_d.pc = (r_q.st_pos < 16'h0004);
            end
        end

        // Phase A carries the record, B idles high meanwhile
        if (r_q.state == abs_out_pkg::SEQ_SERIAL
            || r_q.state == abs_out_pkg::SEQ_ALARM) begin
            r_d.pa = tx_line;
            r_d.pb = 1'b1;
        end else begin
            r_d.pa = nq[1];
            r_d.pb = nq[1] ^ nq[0];
        end

        // APB slave, one wait state
        r_d.pready  = psel && penable && !r_q.pready;
        r_d.pslverr = 1'b0;
        if (psel && penable && !r_q.pready) begin
            r_d.prdata  = 32'h0000_0000;
            r_d.pslverr = 1'b0;
            unique case (paddr)
                `OFF_CTRL: r_d.prdata = {14'h0000, r_q.servo_on,
                                        r_q.edge_sel, r_q.dir_sel,
                                        r_q.pulse_set};
                `OFF_STATUS: r_d.prdata = {29'h0000_0000, r_q.status};
                `OFF_MASK:   r_d.prdata = {29'h0000_0000, r_q.mask};
                `OFF_TURNS:  r_d.prdata = {{15{r_q.turns[16]}}, r_q.turns};
                `OFF_COUNT:  r_d.prdata = r_q.rev_cnt;
                `OFF_STATE:  r_d.prdata = {13'h0000, r_q.st_pos,
                                          r_q.state};
                default:     r_d.pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            unique case (paddr)
                `OFF_CTRL: begin
                    if (pwdata[13:0] >= `SET_MIN) begin
                        r_d.pulse_set = pwdata[13:0];
                    end
                    r_d.dir_sel  = pwdata[`CTRL_DIR_BIT];
                    r_d.edge_sel = abs_out_pkg::edge_sel_t'(
                                   pwdata[`CTRL_EDGE_LSB +: 2]);
                    r_d.servo_on = pwdata[`CTRL_SERVO_BIT];
                    if (pwdata[`CTRL_ERST_BIT]) begin
                        r_d.turns = 17'h0_0000;
                    end
                end
                `OFF_STATUS: r_d.status = r_q.status & ~pwdata[2:0];
                `OFF_MASK:   r_d.mask   = pwdata[2:0];
                default: ;
            endcase
        end
        // New events win over a clear in the same cycle
        r_d.status = r_d.status | ev;
        r_d.irq    = |(r_d.status & r_d.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q           <= '0;
            r_q.state     <= abs_out_pkg::SEQ_IDLE;
            r_q.pulse_set <= `SET_RST;
            r_q.edge_sel  <= abs_out_pkg::edge_sel_t'(`EDGE_RST);
            r_q.mask      <= `MASK_RST;
            r_q.pa        <= 1'b0;
            r_q.pb        <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    assign prdata              = r_q.prdata;
    assign pready              = r_q.pready;
    assign pslverr             = r_q.pslverr;
    assign divided_phase_a_out = r_q.pa;
    assign divided_phase_b_out = r_q.pb;
    assign origin_pulse_out    = r_q.pc;
    assign irq                 = r_q.irq;
endmodule : abs_data_out

// *** host_reader.sv ***
`timescale 1ns/1ns
module host_reader #(
    parameter int BIT_CYCLES = 4
) (
    input  wire logic   pclk,
    input  wire logic   armed,
    input  wire logic   line_a,
    input  wire logic   line_b,
    output logic [55:0] rec,
    output logic [3:0]  n,
    output logic        par_err
);
    logic [9:0] f;
    logic       prev_a;

    initial begin
        rec = '0;
        n = '0;
        par_err = 1'b0;
        prev_a = 1'b1;
    end

    // Origin pulse left unwired while reading
    always begin
        @(posedge pclk);
        if (!armed) begin
            n = '0;
            par_err = 1'b0;
        end else if (!line_a && (prev_a || line_b)) begin
            for (int i = 0; i < 10; i++) begin
                repeat (i == 0 ? BIT_CYCLES / 2 : BIT_CYCLES) @(posedge pclk);
                f[i] = line_a;
            end
            rec = {rec[48:0], f[7:1]};
            n = n + 4'd1;
            par_err = par_err | f[0] | ~f[9] | (^f[8:1]);
        end
        prev_a = line_a;
    end
endmodule : host_reader

// *** abs_data_out_assertions.sv ***
`timescale 1ns/1ns
module abs_data_out_chk #(
    parameter int REQ_WAIT_CYCLES = 50
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        absolute_data_request,
    input wire logic        divided_phase_a_out,
    input wire logic        divided_phase_b_out,
    input wire logic        origin_pulse_out
);
    logic [31:0] wait_q;
    logic [1:0]  ab_q;
    logic        moved_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Cycles since request rose, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q  <= '0;
            ab_q    <= '0;
            moved_q <= 1'b0;
        end else begin
            wait_q  <= !absolute_data_request ? '0 :
                       (wait_q[31] ? wait_q : wait_q + 32'd1);
            ab_q    <= {divided_phase_a_out, divided_phase_b_out};
            moved_q <= {divided_phase_a_out, divided_phase_b_out} != ab_q;
        end
    end

    quiet_wait_a: assert property (
        (wait_q > 0 && wait_q < REQ_WAIT_CYCLES) |->
        $stable(divided_phase_a_out)
    ) else $error("phase A moved during request wait");
    gray_code_a: assert property (
        ($changed(divided_phase_a_out) && $changed(divided_phase_b_out))
        |-> ({divided_phase_a_out, divided_phase_b_out} == 2'b11
             || ab_q == 2'b11)
    ) else $error("phases A and B moved together");
    origin_edge_a: assert property (
        $changed(origin_pulse_out) |->
        ({divided_phase_a_out, divided_phase_b_out} != ab_q) || moved_q
    ) else $error("origin pulse moved off a phase edge");
    ready_once_a: assert property (
        pready |=> !pready
    ) else $error("pready longer than one cycle");
    ready_wait_a: assert property (
        (psel && penable && !pready) |=> pready
    ) else $error("pready not in second access cycle");
    ready_sel_a: assert property (
        pready |-> psel && penable
    ) else $error("pready outside access phase");
    err_ready_a: assert property (
        pslverr |-> pready
    ) else $error("pslverr without pready");
    err_zero_a: assert property (
        pslverr |-> prdata == 32'h0000_0000
    ) else $error("refused read returned data");
endmodule : abs_data_out_chk

bind abs_data_out abs_data_out_chk #(
    .REQ_WAIT_CYCLES(REQ_WAIT_CYCLES)
) abs_data_out_chk_i (
    .pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
    .absolute_data_request, .divided_phase_a_out,
    .divided_phase_b_out, .origin_pulse_out
);

// *** abs_data_out_tb.sv ***
`timescale 1ns/1ns
`include "abs_out_defs.svh"
`define CHK(nm, ex, g) begin checks++; if ((g) !== (ex)) begin \
    bad_count++; $display("FAIL %s exp %0h got %0h", nm, ex, g); end end
module abs_data_out_tb;
    localparam int RW = 50;
    localparam int ST = 200;
    localparam int BC = 4;
    localparam logic [1:0] QUAD [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        absolute_data_request, motion_step, motion_fwd, irq, e;
    logic [15:0] alarm_code;
    logic        divided_phase_a_out, divided_phase_b_out, origin_pulse_out;
    logic        armed, par_err;
    logic [55:0] rec;
    logic [3:0]  n;
    int          bad_count, checks, cyc, t0, dt, t;

    abs_data_out #(
        .REQ_WAIT_CYCLES(RW), .SETTLE_CYCLES(ST), .BIT_CYCLES(BC)
    ) abs_data_out_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .absolute_data_request,
        .motion_step, .motion_fwd, .alarm_code, .divided_phase_a_out,
        .divided_phase_b_out, .origin_pulse_out, .irq
    );
    host_reader #(.BIT_CYCLES(BC)) host_reader_i (
        .pclk, .armed, .line_a(divided_phase_a_out),
        .line_b(divided_phase_b_out), .rec, .n, .par_err
    );

    always #25 pclk = ~pclk;
    always @(posedge pclk) cyc++;

    function automatic logic [55:0] pk(input logic [63:0] s);
        for (int i = 0; i < 8; i++) begin
            pk[7*i +: 7] = s[8*i +: 7];
        end
    endfunction : pk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd_v,
                       output logic er);
        int k;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        `CHK("pready", 1'b1, pready)
        rd_v = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000, r, e);
        `CHK(nm, x, r)
    endtask : rd

    task automatic poll(input logic [2:0] x);
        int k;
        k = 0;
        do begin
            apb(1'b0, `OFF_STATE, 32'h0000_0000, r, e);
            k++;
        end while (r[2:0] !== x && k < 400);
        `CHK("state", x, r[2:0])
    endtask : poll

    task automatic step();
        motion_fwd  <= 1'b1;
        motion_step <= 1'b1;
        @(posedge pclk);
        motion_step <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : step

    task automatic wait_rec();
        for (t = 0; t < 2000 && n !== 4'd8; t++) @(posedge pclk);
        `CHK("chars", 4'd8, n)
    endtask : wait_rec

    task wrap_up;
        if (bad_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (30000) @(posedge pclk);
        bad_count++;
        wrap_up();
    end

    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = '0; pwdata = '0; absolute_data_request = 0; armed = 0;
        motion_step = 0; motion_fwd = 0; alarm_code = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd("ctrl", `OFF_CTRL, 32'h0000_0800);
        rd("status", `OFF_STATUS, 32'h0000_0000);
        rd("mask", `OFF_MASK, 32'h0000_0000);
        rd("turns", `OFF_TURNS, 32'h0000_0000);
        rd("state", `OFF_STATE, 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0000_0000, r, e);
        `CHK("unmapped err", 1'b1, e)
        wr(`OFF_CTRL, 32'h0000_000F);
        rd("set below", `OFF_CTRL, 32'h0000_0800);
        wr(`OFF_CTRL, 32'h0000_0010);
        rd("set min", `OFF_CTRL, 32'h0000_0010);
        for (int d = 0; d < 2; d++) begin
            wr(`OFF_CTRL, 32'h0000_0800 | (32'(d) << 14));
            for (int k = 0; k < 4; k++) begin
                step();
                `CHK("quad", QUAD[k], {divided_phase_a_out, divided_phase_b_out})
                `CHK("origin", d > 0 || k > 0, origin_pulse_out)
            end
        end
        wr(`OFF_CTRL, 32'h0004_0800);
        rd("enc reset", `OFF_TURNS, 32'h0000_0000);
        repeat (3) step();
        wr(`OFF_MASK, 32'h0000_0001);
        armed <= 1'b1;
        absolute_data_request <= 1'b1;
        t0 = cyc;
        for (t = 0; t < 200 && divided_phase_b_out !== 1'b1; t++) @(posedge pclk);
        dt = cyc - t0;
        `CHK("wait", 1'b1, dt >= RW && dt <= RW + 6)
        rd("count", `OFF_COUNT, 32'h0000_0000);
        wait_rec();
        `CHK("record", pk("P+00000\015"), rec)
        `CHK("parity", 1'b0, par_err)
        armed <= 1'b0;
        t0 = cyc;
        poll(3'd0);
        dt = cyc - t0;
        `CHK("settle", 1'b1, dt >= ST - 10 && dt <= ST + 40)
        rd("init pulses", `OFF_COUNT, 32'h0000_0003);
        rd("done flag", `OFF_STATUS, 32'h0000_0001);
        `CHK("irq on", 1'b1, irq)
        wr(`OFF_STATUS, 32'h0000_0001);
        @(posedge pclk);
        `CHK("irq off", 1'b0, irq)
        alarm_code <= 16'h1A2F;
        armed <= 1'b1;
        absolute_data_request <= 1'b0;
        wait_rec();
        `CHK("alarm", pk("ALM1A2F\015"), rec)
        armed <= 1'b0;
        repeat (8) @(posedge pclk);
        rd("alarm flag", `OFF_STATUS, 32'h0000_0002);
        `CHK("irq masked", 1'b0, irq)
        wr(`OFF_MASK, 32'h0000_0002);
        @(posedge pclk);
        `CHK("irq unmasked", 1'b1, irq)
        wr(`OFF_STATUS, 32'h0000_0002);
        wr(`OFF_CTRL, 32'h0002_0800);
        absolute_data_request <= 1'b1;
        repeat (RW + 20) @(posedge pclk);
        apb(1'b0, `OFF_STATE, 32'h0000_0000, r, e);
        `CHK("servo on", 3'd0, r[2:0])
        absolute_data_request <= 1'b0;
        repeat (RW) @(posedge pclk);
        rd("no alarm", `OFF_STATUS, 32'h0000_0000);
        wrap_up();
    end
endmodule : abs_data_out_tb
